// ===== common/ssc_guard_if.sv
// Carrier between the control top and the overload guard.
// Assumes both ends run on the same clock.
interface ssc_guard_if;
   logic pulsed_mode;
   logic overload;
   logic ms_tick;
   logic clear;
   logic output_on;
   logic overload_flag;

   modport ctrl (
      output pulsed_mode, overload, ms_tick, clear,
      input  output_on, overload_flag
   );
   modport guard (
      input  pulsed_mode, overload, ms_tick, clear,
      output output_on, overload_flag
   );
endinterface

// ===== common/ssc_pkg.sv
// Shared constants and types for the satellite supply control block.
// Assumes a single 250 MHz system clock; all slower rates come from dividers.
package ssc_pkg;
   // Clock and time bases
   localparam int CLK_HZ         = 250_000_000;
   localparam int MS_PER_S       = 1000;
   localparam int TICK_CYCLES    = CLK_HZ / MS_PER_S;
   localparam int T_OFF_MS       = 900;
   localparam int T_ON_DIV       = 10;
   localparam int T_ON_MS        = T_OFF_MS / T_ON_DIV;
   localparam int TONE_HZ        = 22_000;
   localparam int TONE_HALF_CYCLES = CLK_HZ / (2 * TONE_HZ);

   // Counter widths
   localparam int TICK_W         = 18;
   localparam int TONE_W         = 13;
   localparam int CNT_W          = 10;
   localparam logic [CNT_W-1:0] OFF_LAST = CNT_W'(T_OFF_MS - 1);
   localparam logic [CNT_W-1:0] ON_LAST  = CNT_W'(T_ON_MS - 1);

   // System word layout
   localparam int BIT_ENABLE     = 0;
   localparam int BIT_LEVEL      = 1;
   localparam int BIT_BOOST      = 2;
   localparam int BIT_TONE       = 3;
   localparam int BIT_CURRENT_THRESHOLD_SELECT       = 4;
   localparam int BIT_PULSE      = 5;
   localparam int BIT_OVERHEAT   = 6;
   localparam int BIT_OVERLOAD   = 7;
   localparam logic [7:0] WORD_RESET = 8'h00;
   localparam logic [7:0] WR_MASK    = 8'h3F;

   // Serial bus
   localparam logic [4:0] I2C_ADDR_HI = 5'h02;
   localparam logic [3:0] BYTE_BITS   = 4'h8;

   // Serial engine states
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_ADDR    = 3'b001,
      ST_ACK_A   = 3'b010,
      ST_WRITE   = 3'b011,
      ST_ACK_W   = 3'b100,
      ST_READ    = 3'b101,
      ST_MACK    = 3'b110,
      ST_MACK_OK = 3'b111
   } ssc_i2c_e;

   // Pulsed limit states
   typedef enum logic [1:0] {
      G_NORMAL = 2'b00,
      G_OFF    = 2'b01,
      G_ON     = 2'b10
   } ssc_guard_e;
endpackage

// ===== rtl/ssc_overload_guard.sv
// Overload guard: pulsed off/on current limit timer and overload flag.
// Assumes overload is already synchronised and ms_tick is a 1 ms pulse.
module ssc_overload_guard
   import ssc_pkg::*;
(
   // Clock and reset
   input wire logic   clk,
   input wire logic   rstn,
   // Guard carrier
   ssc_guard_if.guard g
);
   ssc_guard_e       state;
   logic [CNT_W-1:0] cnt;
   logic             seen;
   logic             flag;
   logic             on_end;

   // Last tick of the on-time
   assign on_end = (state == G_ON) && g.ms_tick && (cnt == ON_LAST);

   // Off/on timer sequence
   always_ff @(posedge clk) begin
      if (!rstn || g.clear || !g.pulsed_mode) begin
         state <= G_NORMAL;
         cnt   <= '0;
         seen  <= 1'b0;
      end else begin
         unique case (state)
            G_NORMAL: if (g.overload) begin
               state <= G_OFF;
               cnt   <= '0;
            end
            G_OFF: if (g.ms_tick) begin
               if (cnt == OFF_LAST) begin
                  state <= G_ON;
                  cnt   <= '0;
                  seen  <= 1'b0;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            G_ON: begin
               if (g.overload)
                  seen <= 1'b1;
               if (on_end) begin
                  cnt <= '0;
                  if (seen || g.overload)
                     state <= G_OFF;
                  else
                     state <= G_NORMAL;
               end else if (g.ms_tick) begin
                  cnt <= cnt + 1'b1;
               end
            end
            default: state <= G_NORMAL;
         endcase
      end
   end

   // Overload flag
   always_ff @(posedge clk) begin
      if (!rstn || g.clear)
         flag <= 1'b0;
      else if (!g.pulsed_mode)
         flag <= g.overload;
      else if (state == G_NORMAL)
         flag <= g.overload;
      else if (on_end && !(seen || g.overload))
         flag <= 1'b0;
   end

   assign g.overload_flag = flag;
   assign g.output_on     = (state != G_OFF);
endmodule

// ===== rtl/ssc_supply_ctrl.sv
// Top of the satellite supply control logic: serial slave, system word,
// power and tone control. Assumes all pins are asynchronous to CLK and
// that the analogue side supplies clean overload and overheat levels.
//
// Function
// - Hold 8-bit word; six bits written, all read, two report status.
// - Standby disables power blocks and closes the bypass switch.
// - When active, level bit picks 13 V or 18 V output.
// - Boost bit raises selected output by about one volt.
// - Tone force bit gives continuous 22 kHz tone, ignoring keying.
// - Tone detector data appears on the tone detect output.
// - Threshold bit high picks lower current limit, low the higher.
// - Pulsed mode overload switches output off 900 ms, flag set.
// - Then output on for a tenth of the off-time.
// - Overload still present after on-time repeats the cycle.
// - Clean full on-time resumes normal operation, flag cleared.
// - Static mode flag follows the current clamp state.
// - Overheat shuts power, opens bypass, sets flag until cooled.
// - Supply undervoltage disables every function.
// - Tone detect output is open collector, low during tone.
// - No acknowledge on the serial bus during undervoltage.
// - Address pin level selects one of four slave addresses.
// - Tone force low gates the carrier with the keying input.
module ssc_supply_ctrl
   import ssc_pkg::*;
#(
   parameter int TICK_N = TICK_CYCLES,
   parameter int TONE_N = TONE_HALF_CYCLES
)(
   // Clock and reset
   input  wire logic       CLK,
   input  wire logic       RSTN,
   // Serial bus, open drain data
   input  wire logic       SCL,
   input  wire logic       SDA_IN,
   output wire logic       SDA_OUT,
   output wire logic       SDA_OE_N,
   input  wire logic [1:0] ADDR_SEL,
   // Supply and sensors
   input  wire logic       SUPPLY_LOW,
   input  wire logic       OVERLOAD,
   input  wire logic       OVERTEMP,
   // Tone path
   input  wire logic       TONE_KEYING_INPUT,
   input  wire logic       TONE_SENSE_INPUT,
   output logic            TONE_OUT,
   output wire logic       TONE_DETECT_OUTPUT,
   output logic            TONE_DETECT_OE_N,
   // Power control
   output logic            REG_ENABLE,
   output logic            OUTPUT_ON,
   output logic            LEVEL_18V,
   output logic            BOOST_1V,
   output logic            ILIM_LOW,
   output logic            BYPASS_CLOSE
);
   localparam int NSYNC = 9;

   logic [NSYNC-1:0] sync1;
   logic [NSYNC-1:0] sync2;
   logic             scl_s, sda_s, uvlo_s, ovl_s, ovt_s, key_s, sense_s;
   logic [1:0]       addr_s;
   logic             scl_d, sda_d;
   logic             start, stop, rise, fall;
   ssc_i2c_e         state;
   logic [3:0]       bitcnt;
   logic [7:0]       sh;
   logic             sda_low;
   logic             wr_stb;
   logic [7:0]       ctrl;
   logic [7:0]       rd_word;
   logic [TICK_W-1:0] tick_cnt;
   logic             ms_tick;
   logic [TONE_W-1:0] tone_cnt;
   logic             carrier;
   logic             active;

   ssc_guard_if gi ();

   // Two-stage synchronisers for every pin
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         sync1 <= {{(NSYNC-2){1'b0}}, 2'b11}; // Bus bits idle high
         sync2 <= {{(NSYNC-2){1'b0}}, 2'b11}; // No false edge on release
      end else begin
         sync1 <= {ADDR_SEL, SUPPLY_LOW, OVERLOAD, OVERTEMP,
                   TONE_KEYING_INPUT, TONE_SENSE_INPUT, SDA_IN, SCL};
         sync2 <= sync1;
      end
   end

   assign scl_s   = sync2[0];
   assign sda_s   = sync2[1];
   assign sense_s = sync2[2];
   assign key_s   = sync2[3];
   assign ovt_s   = sync2[4];
   assign ovl_s   = sync2[5];
   assign uvlo_s  = sync2[6];
   assign addr_s  = sync2[8:7];

   // Previous bus levels for edge detection
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   // Bus conditions
   assign start = scl_s && scl_d && sda_d && !sda_s;
   assign stop  = scl_s && scl_d && !sda_d && sda_s;
   assign rise  = scl_s && !scl_d;
   assign fall  = !scl_s && scl_d;

   // Read-back word with live status bits
   always_comb begin
      rd_word = ctrl & WR_MASK;
      rd_word[BIT_OVERHEAT] = ovt_s;
      rd_word[BIT_OVERLOAD] = gi.overload_flag;
   end

   // Serial slave engine
   always_ff @(posedge CLK) begin
      if (!RSTN || uvlo_s) begin
         state   <= ST_IDLE;
         bitcnt  <= '0;
         sh      <= '0;
         sda_low <= 1'b0;
         wr_stb  <= 1'b0;
      end else begin
         wr_stb <= 1'b0;
         if (start) begin
            state   <= ST_ADDR;
            bitcnt  <= '0;
            sda_low <= 1'b0;
         end else if (stop) begin
            state   <= ST_IDLE;
            sda_low <= 1'b0;
         end else begin
            unique case (state)
               ST_IDLE: ;
               ST_ADDR, ST_WRITE: begin
                  if (rise) begin
                     sh     <= {sh[6:0], sda_s};
                     bitcnt <= bitcnt + 1'b1;
                  end else if (fall && bitcnt == BYTE_BITS) begin
                     bitcnt <= '0;
                     if (state == ST_WRITE) begin
                        state   <= ST_ACK_W;
                        sda_low <= 1'b1;
                        wr_stb  <= 1'b1;
                     end else if (sh[7:1] == {I2C_ADDR_HI, addr_s}) begin
                        state   <= ST_ACK_A;
                        sda_low <= 1'b1;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end
               end
               ST_ACK_A: if (fall) begin
                  if (sh[0]) begin
                     state   <= ST_READ;
                     sh      <= rd_word;
                     sda_low <= !rd_word[7];
                  end else begin
                     state   <= ST_WRITE;
                     sda_low <= 1'b0;
                  end
               end
               ST_ACK_W: if (fall) begin
                  state   <= ST_WRITE;
                  sda_low <= 1'b0;
               end
               ST_READ: begin
                  if (rise) begin
                     bitcnt <= bitcnt + 1'b1;
                  end else if (fall) begin
                     if (bitcnt == BYTE_BITS) begin
                        state   <= ST_MACK;
                        sda_low <= 1'b0;
                        bitcnt  <= '0;
                     end else begin
                        sh      <= {sh[6:0], 1'b0};
                        sda_low <= !sh[6];
                     end
                  end
               end
               ST_MACK: if (rise) begin
                  state <= sda_s ? ST_IDLE : ST_MACK_OK;
               end
               ST_MACK_OK: if (fall) begin
                  state   <= ST_READ;
                  sh      <= rd_word;
                  sda_low <= !rd_word[7];
               end
            endcase
         end
      end
   end

   // Open-drain data: enable low while pulling low
   assign SDA_OUT  = 1'b0;
   assign SDA_OE_N = !sda_low;

   // System word storage
   always_ff @(posedge CLK) begin
      if (!RSTN || uvlo_s)
         ctrl <= WORD_RESET;
      else if (wr_stb)
         ctrl <= sh & WR_MASK;
   end

   // Millisecond tick for the guard timer
   always_ff @(posedge CLK) begin
      if (!RSTN || tick_cnt == TICK_W'(TICK_N - 1))
         tick_cnt <= '0;
      else
         tick_cnt <= tick_cnt + 1'b1;
   end
   assign ms_tick = (tick_cnt == TICK_W'(TICK_N - 1));

   // Carrier generator
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         tone_cnt <= '0;
         carrier  <= 1'b0;
      end else if (tone_cnt == TONE_W'(TONE_N - 1)) begin
         tone_cnt <= '0;
         carrier  <= !carrier;
      end else begin
         tone_cnt <= tone_cnt + 1'b1;
      end
   end

   // Guard hookup; pulsed when the select bit is low
   assign gi.pulsed_mode = !ctrl[BIT_PULSE];
   assign gi.overload    = ovl_s;
   assign gi.ms_tick     = ms_tick;
   assign gi.clear       = uvlo_s;

   ssc_overload_guard u_guard (
      .clk  (CLK),
      .rstn (RSTN),
      .g    (gi.guard)
   );

   assign active = ctrl[BIT_ENABLE] && !ovt_s && !uvlo_s;

   // Power and tone outputs
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         REG_ENABLE   <= 1'b0;
         OUTPUT_ON    <= 1'b0;
         LEVEL_18V    <= 1'b0;
         BOOST_1V     <= 1'b0;
         ILIM_LOW     <= 1'b0;
         BYPASS_CLOSE <= 1'b0;
         TONE_OUT     <= 1'b0;
      end else begin
         REG_ENABLE   <= active;
         OUTPUT_ON    <= active && gi.output_on;
         LEVEL_18V    <= active && ctrl[BIT_LEVEL];
         BOOST_1V     <= active && ctrl[BIT_BOOST];
         ILIM_LOW     <= ctrl[BIT_CURRENT_THRESHOLD_SELECT];
         BYPASS_CLOSE <= !ctrl[BIT_ENABLE] && !ovt_s && !uvlo_s;
         TONE_OUT     <= active && carrier && (ctrl[BIT_TONE] || key_s);
      end
   end

   // Open-collector tone detect output
   assign TONE_DETECT_OUTPUT = 1'b0;
   always_ff @(posedge CLK) begin
      if (!RSTN)
         TONE_DETECT_OE_N <= 1'b1;
      else
         TONE_DETECT_OE_N <= !(sense_s && !uvlo_s);
   end
endmodule

// ===== testbench/ssc_host_model.sv
// Host model: bus master writing and reading the system word.
// Assumes pull-ups on the bus; pacing comes from the bench clock.
module ssc_host_model (
   // Bench clock
   input  wire logic clk,
   // Bus pins
   output logic       scl,
   output logic       sda_o,
   input  wire logic  sda,
   // Read result
   output logic       done,
   output logic [7:0] rd_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic r;
   // Idle bus at start
   initial begin
      scl = 1'b1;
      sda_o = 1'b1;
      done = 1'b0;
      rd_data = 8'h00;
   end
   // Quarter of a 160 ns bus period
   task automatic q;
      repeat (10) @(negedge clk);
   endtask
   // One bit, sampled in mid high phase
   task automatic bitx(input logic b, output logic s);
      sda_o = b;
      q;
      scl = 1'b1;
      q;
      s = sda;
      q;
      scl = 1'b0;
      q;
   endtask
   // Start and stop conditions
   task automatic start;
      sda_o = 1'b1;
      scl = 1'b1;
      q;
      sda_o = 1'b0;
      q;
      scl = 1'b0;
      q;
   endtask
   task automatic stop;
      sda_o = 1'b0;
      q;
      scl = 1'b1;
      q;
      sda_o = 1'b1;
      q;
   endtask
   // Byte out, MSB first, then acknowledge slot
   task automatic put(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--)
         bitx(d[i], r);
      bitx(1'b1, r);
      ack = !r;
   endtask
   // Single byte write
   task automatic wr(input logic [6:0] a, input logic [7:0] d,
                     output logic ack);
      logic k;
      start;
      put({a, 1'b0}, ack);
      put(d, k);
      stop;
   endtask
   // Single byte read, closed by a no-acknowledge
   task automatic rd(input logic [6:0] a, output logic ack);
      logic [7:0] v;
      start;
      put({a, 1'b1}, ack);
      for (int i = 7; i >= 0; i--) begin
         bitx(1'b1, r);
         v[i] = r;
      end
      bitx(1'b1, r);
      stop;
      rd_data = v;
      done = 1'b1;
      q;
      done = 1'b0;
   endtask
endmodule

// ===== testbench/ssc_supply_ctrl_properties.sv
// Checker for the supply control top, bound to every instance.
// Assumes one clock, CLK, and a synchronous active low RSTN.
module ssc_supply_ctrl_properties (
   // Clock and reset
   input wire logic CLK,
   input wire logic RSTN,
   // Bus and sensors
   input wire logic SDA_OE_N,
   input wire logic SUPPLY_LOW,
   input wire logic OVERTEMP,
   input wire logic TONE_SENSE_INPUT,
   // Driven pins
   input wire logic TONE_DETECT_OE_N,
   input wire logic TONE_OUT,
   input wire logic REG_ENABLE,
   input wire logic OUTPUT_ON,
   input wire logic LEVEL_18V,
   input wire logic BOOST_1V,
   input wire logic BYPASS_CLOSE
);
   timeunit 1ns;
   timeprecision 1ps;
   // Shared clock and reset
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   // Pin relations
   AST_LEVEL_GATED: assert property (LEVEL_18V |-> REG_ENABLE)
      else $error("level high in standby");
   AST_BOOST_GATED: assert property (BOOST_1V |-> REG_ENABLE)
      else $error("boost high in standby");
   AST_BYPASS_OPEN: assert property (REG_ENABLE |-> !BYPASS_CLOSE)
      else $error("bypass closed while active");
   AST_OFF_HOLD: assert property
      ($fell(OUTPUT_ON) && REG_ENABLE |=> !OUTPUT_ON [*8])
      else $error("off-time cut short");
   AST_HOT_OFF: assert property
      (OVERTEMP [*5] |-> !REG_ENABLE && !BYPASS_CLOSE)
      else $error("power or bypass on while hot");
   AST_UVLO_OFF: assert property
      (SUPPLY_LOW [*5] |-> !REG_ENABLE && SDA_OE_N && !TONE_OUT)
      else $error("active under lockout");
   AST_DET_LOW: assert property
      ((TONE_SENSE_INPUT && !SUPPLY_LOW) [*5] |-> !TONE_DETECT_OE_N)
      else $error("detect pin not pulled low");
   AST_DET_HIGH: assert property
      (!TONE_SENSE_INPUT [*5] |-> TONE_DETECT_OE_N)
      else $error("detect pin low without tone");
   AST_TONE_IDLE: assert property (!REG_ENABLE [*2] |-> !TONE_OUT)
      else $error("tone in standby");
endmodule

bind ssc_supply_ctrl ssc_supply_ctrl_properties u_props (
   .CLK, .RSTN, .SDA_OE_N, .SUPPLY_LOW, .OVERTEMP, .TONE_SENSE_INPUT,
   .TONE_DETECT_OE_N, .TONE_OUT, .REG_ENABLE, .OUTPUT_ON, .LEVEL_18V,
   .BOOST_1V, .BYPASS_CLOSE);

// ===== testbench/tb.sv
// Self-checking bench for the supply control top.
// Assumes the host model on the bus and shortened tick and tone counts.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ssc_pkg::*;
   localparam int TK = 10;
   localparam int TN = 4;
   logic       clk = 1'b0, rstn = 1'b0, low = 1'b0, ovl = 1'b0;
   logic       hot = 1'b0, key = 1'b0, sen = 1'b0;
   logic [1:0] adr = 2'b00;
   logic       scl, sda_o, sda, done, ack, sda_out, sda_oe_n, tone;
   logic       det, det_oe_n, reg_en, out_on, lvl, bst, ilim, byp;
   logic [7:0] rd_data, v, e;
   logic [7:0] expq[$];
   int         mismatches = 0, n_compared = 0, n;

   // 250 MHz clock and wired-and data line
   always #2 clk = ~clk;
   assign sda = sda_o & (sda_oe_n | sda_out);

   ssc_supply_ctrl #(.TICK_N(TK), .TONE_N(TN)) uut (
      .CLK(clk), .RSTN(rstn), .SCL(scl), .SDA_IN(sda),
      .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .ADDR_SEL(adr),
      .SUPPLY_LOW(low), .OVERLOAD(ovl), .OVERTEMP(hot),
      .TONE_KEYING_INPUT(key), .TONE_SENSE_INPUT(sen),
      .TONE_OUT(tone), .TONE_DETECT_OUTPUT(det),
      .TONE_DETECT_OE_N(det_oe_n), .REG_ENABLE(reg_en),
      .OUTPUT_ON(out_on), .LEVEL_18V(lvl), .BOOST_1V(bst),
      .ILIM_LOW(ilim), .BYPASS_CLOSE(byp));
   ssc_host_model h (.clk(clk), .scl(scl), .sda_o(sda_o), .sda(sda),
      .done(done), .rd_data(rd_data));

   // Compares each read with the oldest note
   always @(posedge done) begin
      e = expq.pop_front();
      n_compared++;
      if (rd_data !== e) begin
         mismatches++;
         $display("Error word expected %h seen %h", e, rd_data);
      end
   end

   // Helpers
   task automatic chk(input string nm, input logic x, input logic g);
      n_compared++;
      if (g !== x) begin
         mismatches++;
         $display("Error %s expected %b seen %b", nm, x, g);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(negedge clk);
   endtask
   task automatic wr(input logic [7:0] d);
      h.wr({I2C_ADDR_HI, adr}, d, ack);
      chk("ack", 1'b1, ack);
   endtask
   task automatic rd_exp(input logic [7:0] x);
      expq.push_back(x);
      h.rd({I2C_ADDR_HI, adr}, ack);
   endtask
   task automatic toggles(output int c);
      logic p;
      c = 0;
      p = tone;
      repeat (64) begin
         @(negedge clk);
         c += int'(tone != p);
         p = tone;
      end
   endtask
   task automatic span(input logic lv, output int c);
      c = 0;
      while (out_on !== lv && c < 20000) begin
         @(negedge clk);
         c++;
      end
   endtask
   task automatic wrap_up;
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Watchdog
   initial begin
      #300us;
      mismatches++;
      wrap_up;
   end

   // Main sequence
   initial begin
      n = $urandom(32'h8ED5);
      cyc(3);
      rstn = 1'b1;
      cyc(8);
      // bench never loads the bypass path
      chk("bypass", 1'b1, byp);
      rd_exp(8'h00);
      $display("Test reset done");
      for (int k = 0; k < 4; k++) begin
         adr = k[1:0];
         cyc(4);
         h.wr({I2C_ADDR_HI, adr ^ 2'b01}, 8'h01, ack);
         chk("foreign ack", 1'b0, ack);
         wr(8'h00);
      end
      $display("Test address done");
      for (int k = 0; k < 6; k++) begin
         v = 8'($urandom) | {7'h60, k[0]};
         wr(v);
         cyc(4);
         chk("regulator", v[0], reg_en);
         chk("bypass", !v[0], byp);
         chk("level", v[0] & v[1], lvl);
         chk("boost", v[0] & v[2], bst);
         chk("low limit", v[4], ilim);
         rd_exp(v & 8'h3F);
      end
      $display("Test word done");
      wr(8'h09);
      toggles(n);
      chk("forced tone", 1'b1, n >= 15 && n <= 17);
      wr(8'h01);
      toggles(n);
      chk("keyed off", 1'b1, n == 0);
      key = 1'b1;
      toggles(n);
      chk("keyed on", 1'b1, n >= 15 && n <= 17);
      key = 1'b0;
      sen = 1'b1;
      cyc(6);
      chk("detect", 1'b0, det_oe_n);
      chk("detect level", 1'b0, det);
      sen = 1'b0;
      cyc(6);
      chk("detect idle", 1'b1, det_oe_n);
      $display("Test tone done");
      wr(8'h21);
      ovl = 1'b1;
      cyc(8);
      chk("static on", 1'b1, out_on);
      rd_exp(8'hA1);
      ovl = 1'b0;
      cyc(8);
      rd_exp(8'h21);
      wr(8'h01);
      ovl = 1'b1;
      cyc(6);
      ovl = 1'b0;
      chk("off", 1'b0, out_on);
      span(1'b1, n);
      chk("off time", 1'b1, n > 8970 && n < 9010);
      ovl = 1'b1;
      cyc(6);
      ovl = 1'b0;
      span(1'b0, n);
      chk("on time", 1'b1, n > 884 && n < 902);
      rd_exp(8'h81);
      span(1'b1, n);
      cyc(950);
      chk("resumed", 1'b1, out_on);
      rd_exp(8'h01);
      $display("Test overload done");
      hot = 1'b1;
      cyc(6);
      chk("hot off", 1'b0, reg_en);
      rd_exp(8'h41);
      wr(8'h00);
      chk("hot bypass", 1'b0, byp);
      hot = 1'b0;
      cyc(6);
      chk("cool bypass", 1'b1, byp);
      wr(8'h01);
      cyc(4);
      chk("cool", 1'b1, reg_en);
      low = 1'b1;
      cyc(6);
      chk("lockout", 1'b0, reg_en);
      h.wr({I2C_ADDR_HI, adr}, 8'h01, ack);
      chk("lockout ack", 1'b0, ack);
      low = 1'b0;
      cyc(6);
      rd_exp(8'h00);
      $display("Test protection done");
      wrap_up;
   end
endmodule
